// ===== hw/nv_wiper_mem.sv
// Stored wiper values and lock bits, one word per resistor network.
// Assumes the caller sequences reads; read data lag the address by one clock.
`timescale 1ns/100ps
`default_nettype none
module nv_wiper_mem import pot_pkg::*; (
	input wire logic clk_sys,
	input wire logic [1:0] raddr,
	output nv_word_type rdata,
	input wire logic [1:0] waddr,
	input wire logic we_wiper,
	input wire logic we_lock,
	input wire nv_word_type wdata
);

	nv_word_type mem [0:3];

	// Stands for nonvolatile cells: no reset, content survives resetn
	initial begin
		for (int i = 0; i < 4; i++) begin
			mem[i] = '{lock: 1'b0, wiper: WIPER_ERASED};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (we_wiper) begin
			mem[waddr].wiper <= wdata.wiper;
		end
		if (we_lock) begin
			mem[waddr].lock <= wdata.lock;
		end
		rdata <= mem[raddr];
	end

endmodule : nv_wiper_mem
`default_nettype wire

// ===== hw/pot_tap_decode.sv
// Maps one volatile wiper value and its terminal bits to switch settings.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module pot_tap_decode import pot_pkg::*; #(
	parameter logic [8:0] FULL = FULL_8
) (
	input wire logic [8:0] wiper,
	input wire terminal_control_reg_type terminal_control_reg,
	output net_out_type dec,
	output logic inc_ok,
	output logic dec_ok
);

	logic over;

	always_comb begin
		over = wiper > FULL;
		dec.tap = over ? FULL : wiper;
		inc_ok = wiper < FULL;
		dec_ok = (wiper != 9'h000) && !over;
		if (!terminal_control_reg.net_shutdown_n) begin
			// Terminal bits are left untouched, only overridden here
			dec.net_term_a_connect = 1'b0;
			dec.net_wiper_connect = 1'b1;
			dec.net_term_b_connect = 1'b1;
			dec.wiper_b_short = 1'b1;
		end else begin
			dec.net_term_a_connect = terminal_control_reg.net_term_a_connect;
			dec.net_wiper_connect = terminal_control_reg.net_wiper_connect;
			dec.net_term_b_connect = terminal_control_reg.net_term_b_connect;
			dec.wiper_b_short = 1'b0;
		end
	end

endmodule : pot_tap_decode
`default_nettype wire

// ===== hw/quad_pot_i2c_wiper_control.sv
// Two-wire slave with four wiper networks, terminal control and locks.
// Assumes an external open-drain resolver for sda; scl is never driven.
`timescale 1ns/100ps
`default_nettype none
module quad_pot_i2c_wiper_control import pot_pkg::*; #(
	parameter logic EIGHT_BIT = 1'b1
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic addr_pin_low,
	input wire logic addr_pin_high,
	input wire logic high_voltage_cmd_in,
	output net_out_type [3:0] net_out,
	output logic [8:0] terminal_control_lo,
	output logic [8:0] terminal_control_hi,
	output logic lock_net0,
	output logic lock_net1,
	output logic lock_net2,
	output logic lock_net3,
	output logic hs_mode,
	output logic boot_done
);

	localparam logic [8:0] FULL = EIGHT_BIT ? FULL_8 : FULL_7;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] a0_s;
		logic [1:0] a1_s;
		logic [1:0] hv_s;
		logic addr_lo;
		logic [2:0] boot_cnt;
		logic boot_done;
		bus_state_type state;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic [1:0] byte_idx;
		logic rw;
		logic hs_mode;
		cmd_type cmd;
		logic [3:0] ptr;
		logic [3:0][8:0] vwiper;
		terminal_control_reg_type [3:0] terminal_control_reg;
		logic [3:0] lock;
		logic sda_oe;
		logic scl_oe;
		net_out_type [3:0] nout;
	} ctl_state_type;

	ctl_state_type st_ff;
	ctl_state_type nxt_st;
	logic [1:0] rst_q_ff;
	logic rst_n;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	net_out_type [3:0] dec_out;
	logic [3:0] inc_ok;
	logic [3:0] dec_ok;
	logic [1:0] mem_raddr;
	logic [1:0] mem_waddr;
	nv_word_type mem_rdata;
	logic mem_we_wiper;
	logic mem_we_lock;
	nv_word_type mem_wdata;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and helpers

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_q_ff <= 2'h0;
		end else begin
			rst_q_ff <= {rst_q_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_q_ff[1];

	function automatic logic [7:0] pack_terminal_control_reg(input terminal_control_reg_type hi, input terminal_control_reg_type lo);
		pack_terminal_control_reg = {hi, lo};
	endfunction : pack_terminal_control_reg

	// Events look at stages 1 and 2 only; stage 0 feeds stage 1 alone
	assign scl_rise = st_ff.scl_s[1] & ~st_ff.scl_s[2];
	assign scl_fall = ~st_ff.scl_s[1] & st_ff.scl_s[2];
	assign start_ev = st_ff.scl_s[1] & st_ff.scl_s[2] & ~st_ff.sda_s[1] & st_ff.sda_s[2];
	assign stop_ev = st_ff.scl_s[1] & st_ff.scl_s[2] & st_ff.sda_s[1] & ~st_ff.sda_s[2];

	assign mem_raddr = st_ff.boot_done ? st_ff.ptr[1:0] : st_ff.boot_cnt[1:0];

	nv_wiper_mem u_mem (
		.clk_sys(clk_sys),
		.raddr(mem_raddr),
		.rdata(mem_rdata),
		.waddr(mem_waddr),
		.we_wiper(mem_we_wiper),
		.we_lock(mem_we_lock),
		.wdata(mem_wdata)
	);

	for (genvar g = 0; g < 4; g++) begin : g_net
		pot_tap_decode #(.FULL(FULL)) u_dec (
			.wiper(st_ff.vwiper[g]),
			.terminal_control_reg(st_ff.terminal_control_reg[g]),
			.dec(dec_out[g]),
			.inc_ok(inc_ok[g]),
			.dec_ok(dec_ok[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [7:0] rd_byte;
		logic ack;
		logic [1:0] tn;
		logic [1:0] bi;
		nxt_st = st_ff;
		rd_byte = 8'hff;
		ack = 1'b0;
		tn = st_ff.cmd.tgt[1:0];
		bi = st_ff.boot_cnt[1:0] - 2'h1;
		mem_we_wiper = 1'b0;
		mem_we_lock = 1'b0;
		mem_waddr = st_ff.cmd.tgt[1:0];
		mem_wdata = '{lock: st_ff.cmd.d8, wiper: {st_ff.cmd.d8, st_ff.shreg}};
		nxt_st.scl_s = {st_ff.scl_s[1:0], scl_i};
		// Works down to a half period of 4 clocks; high-speed rate only flagged
		nxt_st.sda_s = {st_ff.sda_s[1:0], sda_i};
		nxt_st.a0_s = {st_ff.a0_s[0], addr_pin_low};
		nxt_st.a1_s = {st_ff.a1_s[0], addr_pin_high};
		nxt_st.hv_s = {st_ff.hv_s[0], high_voltage_cmd_in};
		nxt_st.nout = dec_out;
		nxt_st.scl_oe = 1'b0;

		if (st_ff.ptr < TGT_NV) begin
			rd_byte = st_ff.vwiper[st_ff.ptr[1:0]][7:0];
		end else if (st_ff.ptr < TGT_TERMINAL_CONTROL_REG_LO) begin
			rd_byte = mem_rdata.wiper[7:0];
		end else if (st_ff.ptr == TGT_TERMINAL_CONTROL_REG_LO) begin
			rd_byte = pack_terminal_control_reg(st_ff.terminal_control_reg[1], st_ff.terminal_control_reg[0]);
		end else if (st_ff.ptr == TGT_TERMINAL_CONTROL_REG_HI) begin
			rd_byte = pack_terminal_control_reg(st_ff.terminal_control_reg[3], st_ff.terminal_control_reg[2]);
		end

		if (!st_ff.boot_done) begin
			if (st_ff.boot_cnt != 3'h0) begin
				nxt_st.vwiper[bi] = mem_rdata.wiper;
				nxt_st.lock[bi] = mem_rdata.lock;
			end
			if (st_ff.boot_cnt == BOOT_LAST) begin
				// Synchronisers are full by now, so the pin level is real
				nxt_st.addr_lo = st_ff.a0_s[1];
				nxt_st.boot_done = 1'b1;
			end else begin
				nxt_st.boot_cnt = st_ff.boot_cnt + 3'h1;
			end
		end else if (start_ev) begin
			nxt_st.state = ST_RX;
			nxt_st.bit_cnt = 4'h0;
			nxt_st.byte_idx = 2'h0;
			nxt_st.sda_oe = 1'b0;
		end else if (stop_ev) begin
			nxt_st.state = ST_IDLE;
			nxt_st.hs_mode = 1'b0;
			nxt_st.sda_oe = 1'b0;
		end else begin
			case (st_ff.state)
				ST_RX: begin
					if (scl_rise) begin
						nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_s[1]};
						nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
					end else if (scl_fall && st_ff.bit_cnt == BYTE_BITS) begin
						nxt_st.bit_cnt = 4'h0;
						case (st_ff.byte_idx)
							2'h0: begin
								// Only a seven-bit match; ten-bit headers never match
								if (st_ff.shreg[7:1] == {DEV_CODE, st_ff.a1_s[1], st_ff.addr_lo}) begin
									ack = 1'b1;
									nxt_st.rw = st_ff.shreg[0];
									nxt_st.byte_idx = 2'h1;
								end else if (st_ff.shreg[7:3] == HS_CODE) begin
									nxt_st.hs_mode = 1'b1;
								end
							end
							2'h1: begin
								nxt_st.cmd = st_ff.shreg;
								nxt_st.ptr = st_ff.shreg[7:4];
								ack = st_ff.shreg[7:4] <= TGT_TERMINAL_CONTROL_REG_HI;
								nxt_st.byte_idx = (st_ff.shreg[3:2] == OP_WRITE) ? 2'h2 : 2'h1;
								tn = st_ff.shreg[5:4];
								if (st_ff.shreg[7:4] < TGT_NV && !st_ff.lock[tn]) begin
									if (st_ff.shreg[3:2] == OP_INC && inc_ok[tn]) begin
										nxt_st.vwiper[tn] = st_ff.vwiper[tn] + 9'h001;
									end
									if (st_ff.shreg[3:2] == OP_DEC && dec_ok[tn]) begin
										nxt_st.vwiper[tn] = st_ff.vwiper[tn] - 9'h001;
									end
								end
								if (st_ff.shreg[7:4] < TGT_NV && st_ff.shreg[3:2] == OP_SPECIAL
										&& st_ff.hv_s[1]) begin
									nxt_st.lock[tn] = st_ff.shreg[0];
									mem_we_lock = 1'b1;
									// Command is not registered yet; address from this byte
									mem_waddr = tn;
									mem_wdata.lock = st_ff.shreg[0];
								end
							end
							default: begin
								ack = 1'b1;
								nxt_st.byte_idx = 2'h1;
								if (st_ff.cmd.tgt < TGT_NV && !st_ff.lock[tn]) begin
									nxt_st.vwiper[tn] = {st_ff.cmd.d8, st_ff.shreg};
								end
								if (st_ff.cmd.tgt >= TGT_NV && st_ff.cmd.tgt < TGT_TERMINAL_CONTROL_REG_LO) begin
									mem_we_wiper = !st_ff.lock[tn];
								end
								for (int k = 0; k < 4; k++) begin
									if (!st_ff.lock[k] && st_ff.cmd.tgt[0] == k[1]
											&& st_ff.cmd.tgt[3:1] == TGT_TERMINAL_CONTROL_REG_LO[3:1]) begin
										nxt_st.terminal_control_reg[k] = k[0] ? st_ff.shreg[7:4] : st_ff.shreg[3:0];
									end
								end
							end
						endcase
						nxt_st.state = ack ? ST_ACK : ST_WAIT;
						nxt_st.sda_oe = ack;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						nxt_st.sda_oe = 1'b0;
						nxt_st.state = ST_RX;
						if (st_ff.rw) begin
							// Read byte is already settled, so no stretching is needed
							nxt_st.state = ST_TX;
							nxt_st.shreg = rd_byte;
							nxt_st.sda_oe = ~rd_byte[7];
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (st_ff.bit_cnt[2:0] == TX_LAST) begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.bit_cnt = 4'h0;
							nxt_st.state = ST_TXACK;
						end else begin
							nxt_st.shreg = {st_ff.shreg[6:0], 1'b1};
							nxt_st.sda_oe = ~st_ff.shreg[6];
							nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						nxt_st.state = st_ff.sda_s[1] ? ST_WAIT : ST_ACK;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.scl_s <= 3'h7;
			st_ff.sda_s <= 3'h7;
			st_ff.terminal_control_reg <= {4{TERMINAL_CONTROL_REG_RST}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign scl_o = st_ff.scl_oe;
	assign scl_oe = st_ff.scl_oe;
	assign sda_o = st_ff.scl_oe;
	assign sda_oe = st_ff.sda_oe;
	assign net_out = st_ff.nout;
	assign terminal_control_lo = {TERMINAL_CONTROL_REG_D8, st_ff.terminal_control_reg[1], st_ff.terminal_control_reg[0]};
	assign terminal_control_hi = {TERMINAL_CONTROL_REG_D8, st_ff.terminal_control_reg[3], st_ff.terminal_control_reg[2]};
	assign lock_net0 = st_ff.lock[0];
	assign lock_net1 = st_ff.lock[1];
	assign lock_net2 = st_ff.lock[2];
	assign lock_net3 = st_ff.lock[3];
	assign hs_mode = st_ff.hs_mode;
	assign boot_done = st_ff.boot_done;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	AST_START_RX: assert property (st_ff.boot_done && start_ev |=> st_ff.state == ST_RX && st_ff.bit_cnt == 4'h0 && st_ff.byte_idx == 2'h0) else $error("start did not restart receiver");
	AST_STOP_IDLE: assert property (st_ff.boot_done && stop_ev && !start_ev |=> st_ff.state == ST_IDLE && !st_ff.hs_mode) else $error("stop did not idle");
	AST_SCL_FREE: assert property (!scl_oe) else $error("serial clock driven");
	AST_ACK_SLOT: assert property (st_ff.state == ST_ACK && !$past(st_ff.rw) |-> sda_oe && !sda_o) else $error("ack not driven low");
	AST_HS_NACK: assert property (st_ff.boot_done && !start_ev && !stop_ev && st_ff.state == ST_RX && st_ff.byte_idx == 2'h0 && scl_fall && st_ff.bit_cnt == BYTE_BITS && st_ff.shreg[7:3] == HS_CODE |=> !sda_oe && st_ff.hs_mode && st_ff.state == ST_WAIT) else $error("master code handled wrong");
	AST_ADDR_HELD: assert property (st_ff.boot_done |=> $stable(st_ff.addr_lo)) else $error("address bit moved after reset");
	AST_LOCK_HOLDS: assert property ($past(st_ff.lock[0]) && $past(st_ff.boot_done) |-> $stable(st_ff.vwiper[0]) && $stable(st_ff.terminal_control_reg[0])) else $error("locked network changed");
	AST_TAP_CLAMP: assert property (st_ff.vwiper[1] > FULL |=> net_out[1].tap == FULL) else $error("over range not clamped");
	AST_HW_SHUTDOWN_PIN_STATE: assert property (!st_ff.terminal_control_reg[2].net_shutdown_n |=> !net_out[2].net_term_a_connect && net_out[2].wiper_b_short) else $error("shutdown state wrong");
	AST_TAP_FOLLOWS: assert property (st_ff.vwiper[0] <= FULL |=> net_out[0].tap == $past(st_ff.vwiper[0])) else $error("tap lost wiper value");
	AST_TERMINAL_CONTROL_REG_KEPT: assert property (st_ff.terminal_control_reg[0].net_shutdown_n && $past(!st_ff.terminal_control_reg[0].net_shutdown_n) && $stable(st_ff.terminal_control_reg[0].net_term_a_connect) |=> net_out[0].net_term_a_connect == $past(st_ff.terminal_control_reg[0].net_term_a_connect)) else $error("terminal bits not restored");

endmodule : quad_pot_i2c_wiper_control
`default_nettype wire

// ===== pkg/pot_pkg.sv
// Shared constants and types for the quad wiper controller with two-wire slave.
// Assumes one 25 MHz system clock; bus pins arrive asynchronously.
//
// Contract
// - Above full scale: wiper at A, no inc/dec
// - At full scale: wiper at A, no increment
// - At zero: wiper at B, no decrement
// - Lock bit blocks wiper and terminal writes
// - Lock changes only by high-voltage commands
// - Lock state survives power-on reset
// - Reset reloads volatile wipers from stored values
// - Volatile terminal bits connect A, W, B separately
// - Shutdown bit low: A open, W to B
// - Shutdown ignores but keeps terminal bits
// - Shutdown keeps wiper; release restores position
// - Slave only, never drives serial clock
// - Never stretches clock; read data ready
// - Data sampled on serial clock rise
// - Data change with clock high is start/stop
// - Data falling with clock high starts sequence
// - Clock rates up to 100k/400k/3.4M; 3.4M is only flagged in hs_mode, the slave needs a half period of 4 clocks
// - Seven-bit addressing only, no ten-bit
// - Address byte parsed first after start
// - Low address pin latched at reset
// - Acknowledge drives data low in ninth slot
// - Address bits 6:2 are 01011 plus pins
// - Stop resets serial state machine to idle
// - New start resets command state machine
// - Master code 00001xxx: no ack, high-speed until stop
package pot_pkg;

	localparam logic [4:0] DEV_CODE = 5'h0b;
	localparam logic [4:0] HS_CODE = 5'h01;
	localparam logic [8:0] FULL_8 = 9'h100;
	localparam logic [8:0] FULL_7 = 9'h080;
	localparam logic [8:0] WIPER_ERASED = 9'h080;
	localparam logic [3:0] TERMINAL_CONTROL_REG_RST = 4'hf;
	localparam logic TERMINAL_CONTROL_REG_D8 = 1'b1;
	localparam logic [3:0] TGT_NV = 4'h4;
	localparam logic [3:0] TGT_TERMINAL_CONTROL_REG_LO = 4'h8;
	localparam logic [3:0] TGT_TERMINAL_CONTROL_REG_HI = 4'h9;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] TX_LAST = 3'h7;
	localparam logic [2:0] BOOT_LAST = 3'h4;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_INC = 2'h1,
		OP_DEC = 2'h2,
		OP_SPECIAL = 2'h3
	} op_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_ACK = 3'h2,
		ST_TX = 3'h3,
		ST_TXACK = 3'h4,
		ST_WAIT = 3'h5
	} bus_state_type;

	typedef struct packed {
		logic [3:0] tgt;
		op_type op;
		logic rsvd;
		logic d8;
	} cmd_type;

	typedef struct packed {
		logic net_shutdown_n;
		logic net_term_a_connect;
		logic net_wiper_connect;
		logic net_term_b_connect;
	} terminal_control_reg_type;

	typedef struct packed {
		logic [8:0] tap;
		logic net_term_a_connect;
		logic net_wiper_connect;
		logic net_term_b_connect;
		logic wiper_b_short;
	} net_out_type;

	typedef struct packed {
		logic lock;
		logic [8:0] wiper;
	} nv_word_type;

endpackage : pot_pkg

// ===== sim/i2c_master_model.sv
// Behavioural two-wire bus master that drives the far side of the wiper controller.
// Assumes the bench resolves both open-drain lines with pull-ups; tasks are called in sequence.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
	input wire logic clk_sys,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	localparam time Q = 80;
	// Extra low time lets the bench act as a slow master
	time lo_extra = 0;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	////////////////////////////////////////
	// Waits a quarter period first so the slave can release its acknowledge
	task automatic start_cond();
		@(negedge clk_sys);
		#Q sda_drv = 1'b1;
		#Q scl = 1'b1;
		#Q sda_drv = 1'b0;
		#Q scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		#Q sda_drv = 1'b0;
		#Q scl = 1'b1;
		#Q sda_drv = 1'b1;
		#Q;
	endtask : stop_cond
	// Data moves only while scl is low; the clock stands high between frames
	task automatic clock_bit(input logic b, output logic s);
		#(Q + lo_extra) sda_drv = b;
		#Q scl = 1'b1;
		#Q s = sda_line;
		#Q scl = 1'b0;
	endtask : clock_bit
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(d[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
	endtask : send_byte
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			d[i] = s;
		end
		clock_bit(last, s);
	endtask : recv_byte
endmodule : i2c_master_model
`default_nettype wire

// ===== sim/quad_pot_i2c_wiper_control_test.sv
// Self-checking bench for the quad wiper controller and its two-wire slave.
// Assumes the bus master model beside it; pull-ups on both lines are resolved here.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) check(32'(g), 32'(e))
module quad_pot_i2c_wiper_control_test import pot_pkg::*;;
	typedef struct packed {
		op_type op;
		logic [8:0] val;
		logic [8:0] tap;
		logic [7:0] rd;
	} row_type;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic scl_o, scl_oe, sda_o, sda_oe, scl, sda_drv;
	logic addr_pin_low = 1'b0;
	logic addr_pin_high = 1'b1; // Held static for the whole run
	logic high_voltage_cmd_in = 1'b0;
	net_out_type [3:0] net_out;
	logic [8:0] tc_lo, tc_hi;
	logic [3:0] locks;
	logic hs_mode, boot_done, ack_all;
	logic scl_driven = 1'b0;
	logic [7:0] addr_w = 8'h5c;
	logic [7:0] rd;
	int n_fail = 0;
	int compares = 0;
	wire logic scl_bus = scl & ~(scl_oe & ~scl_o);
	wire logic sda_bus = sda_drv & ~(sda_oe & ~sda_o);
	row_type rows [11] = '{
		'{OP_WRITE, 9'h000, 9'h000, 8'h00}, '{OP_DEC, 9'h000, 9'h000, 8'h00},
		'{OP_INC, 9'h000, 9'h001, 8'h01}, '{OP_WRITE, 9'h0ff, 9'h0ff, 8'hff},
		'{OP_INC, 9'h000, 9'h100, 8'h00}, '{OP_INC, 9'h000, 9'h100, 8'h00},
		'{OP_DEC, 9'h000, 9'h0ff, 8'hff}, '{OP_WRITE, 9'h1ff, 9'h100, 8'hff},
		'{OP_DEC, 9'h000, 9'h100, 8'hff}, '{OP_INC, 9'h000, 9'h100, 8'hff},
		'{OP_WRITE, 9'h080, 9'h080, 8'h80}};
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (scl_oe !== 1'b0 || scl_o !== 1'b0 || sda_o !== 1'b0)
			scl_driven <= 1'b1;
	end
	quad_pot_i2c_wiper_control dut_u (.clk_sys(clk_sys), .resetn(resetn), .scl_i(scl_bus),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_pin_low(addr_pin_low), .addr_pin_high(addr_pin_high),
		.high_voltage_cmd_in(high_voltage_cmd_in), .net_out(net_out),
		.terminal_control_lo(tc_lo), .terminal_control_hi(tc_hi), .lock_net0(locks[0]),
		.lock_net1(locks[1]), .lock_net2(locks[2]), .lock_net3(locks[3]), .hs_mode(hs_mode),
		.boot_done(boot_done));
	i2c_master_model master_u (.clk_sys(clk_sys), .sda_line(sda_bus), .scl(scl),
		.sda_drv(sda_drv));
	////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic do_reset();
		resetn = 1'b0;
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		for (int i = 0; i < 200 && boot_done !== 1'b1; i++)
			@(negedge clk_sys);
		if (boot_done !== 1'b1) begin
			n_fail++;
			complete_run();
		end
		repeat (2) @(negedge clk_sys);
	endtask : do_reset
	task automatic put(input logic [7:0] d);
		logic a;
		master_u.send_byte(d, a);
		ack_all &= a;
	endtask : put
	task automatic frame(input logic [3:0] tgt, input op_type op, input logic [8:0] v);
		ack_all = 1'b1;
		master_u.start_cond();
		put(addr_w);
		put({tgt, op, 1'b0, v[8]});
		if (op == OP_WRITE)
			put(v[7:0]);
		master_u.stop_cond();
		repeat (4) @(negedge clk_sys);
	endtask : frame
	// Pointer set by a special command, so never call this with the lock input high
	task automatic read_back(input logic [3:0] tgt);
		ack_all = 1'b1;
		master_u.start_cond();
		put(addr_w);
		put({tgt, OP_SPECIAL, 2'b00});
		master_u.start_cond();
		put(addr_w | 8'h01);
		master_u.recv_byte(1'b1, rd);
		master_u.stop_cond();
		repeat (4) @(negedge clk_sys);
	endtask : read_back
	////////////////////////////////////////
	initial begin
		do_reset();
		`CHECK({tc_lo, tc_hi, locks, hs_mode, sda_oe}, {18'h3ffff, 6'h00});
		foreach (rows[i]) begin
			master_u.lo_extra = (i % 2) * 400;
			frame(4'h1, rows[i].op, rows[i].val);
			read_back(4'h1);
			`CHECK({net_out[1].tap, rd, ack_all}, {rows[i].tap, rows[i].rd, 1'b1});
		end
		$display("test wiper_table done");
		addr_pin_low = 1'b1;
		frame(4'h0, OP_INC, 9'h000);
		`CHECK({ack_all, net_out[0].tap}, {1'b1, 9'h081});
		addr_w = 8'h5e;
		frame(4'h0, OP_INC, 9'h000);
		`CHECK({ack_all, net_out[0].tap}, {1'b0, 9'h081});
		ack_all = 1'b1;
		master_u.start_cond();
		put(8'h08);
		`CHECK({ack_all, hs_mode}, 2'b01);
		master_u.stop_cond();
		repeat (4) @(negedge clk_sys);
		`CHECK(hs_mode, 1'b0);
		$display("test addressing done");
		addr_w = 8'h5c;
		frame(TGT_TERMINAL_CONTROL_REG_LO, OP_WRITE, 9'h0f7);
		`CHECK({tc_lo, net_out[0]}, {9'h1f7, 9'h081, 4'b0111});
		frame(TGT_TERMINAL_CONTROL_REG_LO, OP_WRITE, 9'h0f5);
		`CHECK({tc_lo, net_out[0]}, {9'h1f5, 9'h081, 4'b0111});
		frame(TGT_TERMINAL_CONTROL_REG_LO, OP_WRITE, 9'h0fd);
		`CHECK({tc_lo, net_out[0]}, {9'h1fd, 9'h081, 4'b1010});
		$display("test shutdown done");
		frame(4'h7, OP_WRITE, 9'h033);
		frame(4'h2, OP_SPECIAL, 9'h100);
		`CHECK(locks, 4'h0);
		high_voltage_cmd_in = 1'b1;
		frame(4'h2, OP_SPECIAL, 9'h100);
		high_voltage_cmd_in = 1'b0;
		`CHECK(locks, 4'h4);
		frame(4'h2, OP_INC, 9'h000);
		frame(TGT_TERMINAL_CONTROL_REG_HI, OP_WRITE, 9'h000);
		frame(4'h6, OP_WRITE, 9'h011);
		read_back(4'h6);
		`CHECK({net_out[2].tap, tc_hi, rd, ack_all}, {9'h080, 9'h10f, 8'h80, 1'b1});
		$display("test lock done");
		do_reset();
		`CHECK({locks, net_out[3].tap, net_out[1].tap, tc_hi}, {4'h4, 9'h033, 9'h080, 9'h1ff});
		addr_w = 8'h5e;
		frame(4'h0, OP_INC, 9'h000);
		`CHECK({ack_all, net_out[0].tap}, {1'b1, 9'h081});
		high_voltage_cmd_in = 1'b1;
		frame(4'h2, OP_SPECIAL, 9'h000);
		high_voltage_cmd_in = 1'b0;
		`CHECK(locks, 4'h0);
		`CHECK(scl_driven, 1'b0);
		$display("test reset_reload done");
		complete_run();
	end
endmodule : quad_pot_i2c_wiper_control_test
`default_nettype wire
